// ### design/pin_sync.sv
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic core_clk, // system clock
   input wire logic rst,      // async reset
   sync_if.sink     port      // raw in, clean out
);
   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] clean_reg;

   // three stage chain; s1 only feeds s2 to keep metastability contained
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
      end else begin
         s1_reg <= port.raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a bit changes only once stages two and three agree
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         clean_reg <= '0;
      end else begin
         for (int i = 0; i < WIDTH; i++) begin
            if (s2_reg[i] == s3_reg[i]) begin
               clean_reg[i] <= s3_reg[i];
            end
         end
      end
   end

   assign port.clean = clean_reg;
endmodule

// ### design/sync_if.sv
`timescale 1ns/1ps
// raw pin levels in, filtered levels out
interface sync_if #(parameter int WIDTH = 1);
   logic [WIDTH-1:0] raw;
   logic [WIDTH-1:0] clean;
   modport sink (input raw, output clean);
   modport user (output raw, input clean);
endinterface

// ### design/trig_pkg.sv
package trig_pkg;
   // clock and prompt pulse timing
   localparam int CLK_KHZ = 40000;
   localparam int ACCEPT_NS = 1000;
   localparam int ACCEPT_CYCLES = (ACCEPT_NS * CLK_KHZ + 999999) / 1000000;
   localparam logic [5:0] ACCEPT_LAST = 6'(ACCEPT_CYCLES - 1);

   // register offsets (byte address within the 16-byte window)
   localparam logic [3:0] OFF_CSR = 4'h0;
   localparam logic [3:0] OFF_VEC = 4'h2;
   localparam logic [3:0] OFF_TDR = 4'h4;
   localparam logic [3:0] OFF_OUT = 4'h6;
   localparam logic [3:0] OFF_INP = 4'h8;

   // control_status_reg fields
   localparam int CSR_EXT = 0;
   localparam int CSR_EN_TRIG = 1;
   localparam int CSR_EN_INT = 2;
   localparam int CSR_TEST = 3;
   localparam int CSR_SOFT_RST = 7;
   localparam int CSR_LVL_LSB = 8;
   localparam int CSR_PEND = 14;
   localparam int CSR_VALID = 15;

   // trigger data register fields
   localparam int TDR_MODE = 7;
   localparam int TDR_TEST_INT = 8;
   localparam int TDR_ACK = 15;
   localparam logic [15:0] TDR_ONES = 16'h7e00;

   // unused upper bytes of the vector and output registers read as one
   localparam logic [15:0] HI_ONES = 16'hff00;
   localparam logic [15:0] ALL_ONES = 16'hffff;

   // reset values
   localparam logic [3:0] CSR_RST = 4'h0;
   localparam logic [7:0] VEC_RST = 8'h00;
   localparam logic [7:0] OUT_RST = 8'h00;
   localparam logic [5:0] TDATA_RST = 6'h00;

   // short address modifiers accepted
   localparam logic [5:0] AM_SHORT_SUP = 6'h2d;
   localparam logic [5:0] AM_SHORT_USR = 6'h29;

   // pin group widths
   localparam int CODE_W = 6;
   localparam int STATIONS = 8;
   localparam int SYNC_W = 13;

   // external trigger sequencer
   typedef enum logic [2:0] {
      EXT_IDLE   = 3'b001,
      EXT_ACCEPT = 3'b010,
      EXT_BUSY   = 3'b100
   } ext_state_e;
endpackage

// ### design/trigger_readout_interface.sv
// The Wishbone register port and the address map were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// - triggers come from one source only, cable or external, chosen by mode bit.
// - cable carries six bits: sync flag, late fail flag, four-bit station code.
// - master sends no new code until every station has acknowledged.
// - external mode takes four free-running triggers and two data levels.
// - OR of triggers rising latches all six input lines at once.
// - after latching, further triggers are ignored and prompt accept pulses.
// - external mode stays busy until host clears it.
// - valid data with interrupts enabled raises the interrupt request.
// - valid data sets a status flag readable by polling.
// - eight-bit general purpose output port usable in any mode.
// - in master mode the six inputs form an input port sampled on read.
// - up to eight stations, each with its own acknowledge line.
// - prompt accept output marks an accepted external trigger.
// - busy output stands while a trigger is processed; cable captures leave busy low.
// - bus slave with sixteen-bit address and sixteen-bit data.
// - both short supervisory and short user modifiers reach every register.
// - interrupter on levels one to seven, byte vector, released on acknowledge.
// - base decoded from address bits fifteen to four against switches.
// - control bit 0 external mode, bit 1 trigger enable, bit 2 interrupt enable.
// - control bit 15 reads set while valid trigger data is held.
// - data register bit 15 write acknowledges master or clears busy.
// - programmable byte vector returned in interrupt acknowledge cycle.
module trigger_readout_interface
   import trig_pkg::*;
(
   input  wire logic                  core_clk,      // 40 MHz clock
   input  wire logic                  rst,           // async reset, high
   input  wire logic                  wb_cyc_i,      // wishbone cycle
   input  wire logic                  wb_stb_i,      // wishbone strobe
   input  wire logic                  wb_we_i,       // write enable
   input  wire logic [15:0]           wb_adr_i,      // byte address
   input  wire logic [1:0]            wb_sel_i,      // byte lanes
   input  wire logic [15:0]           wb_dat_i,      // write data
   input  wire logic [5:0]            am_i,          // address modifier
   output logic      [15:0]           wb_dat_o,      // read data
   output logic                       wb_ack_o,      // access done
   output logic                       wb_err_o,      // refused access
   input  wire logic [11:0]           base_sw,       // base switches a15..a4
   input  wire logic [2:0]            irq_level_sw,  // interrupt level switches
   input  wire logic [2:0]            station_sel,   // station number jumper
   output logic                       irq_req,       // interrupt request
   input  wire logic                  iack_stb,      // acknowledge cycle
   input  wire logic [2:0]            iack_level,    // level being acknowledged
   output logic                       iack_ack,      // vector valid pulse
   output logic      [7:0]            iack_vector,   // returned vector
   input  wire logic                  cable_strobe,  // master strobe pin
   input  wire logic [CODE_W-1:0]     cable_code,    // master code pins
   input  wire logic [STATIONS-1:0]   ack_from_next, // acks from downstream
   output logic      [STATIONS-1:0]   ack_to_master, // acks toward master
   input  wire logic [3:0]            ext_trig,      // external trigger pins
   input  wire logic [1:0]            ext_data,      // data level pins
   output logic                       prompt_accept, // accept pulse
   output logic                       busy,          // busy level
   output logic      [7:0]            gp_out         // output port
);
   import trig_pkg::*;

   // pin filtering for the cable strobe, cable code, external trigger and data pins
   sync_if #(.WIDTH(SYNC_W)) pins ();
   assign pins.raw = {cable_strobe, cable_code, ext_data, ext_trig};

   pin_sync #(
      .WIDTH (SYNC_W)
   ) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .port     (pins)
   );

   logic              strb_s;
   logic [5:0]        code_s;
   logic [5:0]        ext_s;
   assign strb_s = pins.clean[12];
   assign code_s = pins.clean[11:6];
   assign ext_s  = pins.clean[5:0];

   // register state
   logic [3:0]        ctrl_reg;
   logic [7:0]        vec_reg;
   logic [7:0]        out_reg;
   logic [5:0]        tdata_reg;
   logic              valid_reg;
   logic              pend_reg;
   logic              mack_reg;
   logic              ack_reg;
   logic              err_reg;
   logic [15:0]       rdat_reg;
   logic              iack_reg;
   logic [7:0]        ivec_reg;
   logic              strb_d_reg;
   logic              or_d_reg;
   logic [5:0]        cnt_reg;
   ext_state_e        state_reg;

   logic              mode_ext;
   logic              trig_en;
   assign mode_ext = ctrl_reg[CSR_EXT];
   assign trig_en  = ctrl_reg[CSR_EN_TRIG];

   // bus decode: base match and short modifier both needed
   logic              access;
   logic              am_ok;
   logic              hit;
   logic              wr;
   logic              rd;
   logic [3:0]        off;
   assign access = wb_cyc_i & wb_stb_i & ~ack_reg & ~err_reg;
   assign am_ok  = (am_i == AM_SHORT_SUP) | (am_i == AM_SHORT_USR);
   assign hit    = (wb_adr_i[15:4] == base_sw) & am_ok;
   assign wr     = access & hit & wb_we_i;
   assign rd     = access & hit & ~wb_we_i;
   assign off    = wb_adr_i[3:0];

   // write strobes for the side effects of writes
   logic              wr_csr_lo;
   logic              soft_clr;
   logic              tdr_hi;
   logic              tdr_ack;
   logic              test_int;
   assign wr_csr_lo = wr & (off == OFF_CSR) & wb_sel_i[0];
   assign soft_clr  = wr_csr_lo & wb_dat_i[CSR_SOFT_RST];
   assign tdr_hi    = wr & (off == OFF_TDR) & wb_sel_i[1];
   assign tdr_ack   = tdr_hi & wb_dat_i[TDR_ACK];
   assign test_int  = tdr_hi & wb_dat_i[TDR_TEST_INT] & ctrl_reg[CSR_TEST]
                      & ctrl_reg[CSR_EN_INT];

   // trigger capture from whichever source is selected
   logic              strb_rise;
   logic              trig_or;
   logic              or_rise;
   logic              cap_ts;
   logic              cap_ext;
   logic              cap;
   assign strb_rise = strb_s & ~strb_d_reg;
   assign trig_or   = |ext_s[3:0];
   assign or_rise   = trig_or & ~or_d_reg;
   assign cap_ts    = ~mode_ext & trig_en & strb_rise & ~soft_clr;
   assign cap_ext   = mode_ext & trig_en & or_rise & ~soft_clr
                      & (state_reg == EXT_IDLE);
   assign cap       = cap_ts | cap_ext;

   // edge history of the filtered strobe and trigger OR
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         strb_d_reg <= 1'b0;
         or_d_reg   <= 1'b0;
      end else begin
         strb_d_reg <= strb_s;
         or_d_reg   <= trig_or;
      end
   end

   // control bits; the reset pulse bit is not stored
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= CSR_RST;
      end else if (soft_clr) begin
         ctrl_reg <= CSR_RST;
      end else if (wr_csr_lo) begin
         ctrl_reg <= wb_dat_i[3:0];
      end
   end

   // interrupt vector and output port
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         vec_reg <= VEC_RST;
         out_reg <= OUT_RST;
      end else if (soft_clr) begin
         vec_reg <= VEC_RST;
         out_reg <= OUT_RST;
      end else begin
         if (wr & (off == OFF_VEC) & wb_sel_i[0]) begin
            vec_reg <= wb_dat_i[7:0];
         end
         if (wr & (off == OFF_OUT) & wb_sel_i[0]) begin
            out_reg <= wb_dat_i[7:0];
         end
      end
   end

   // trigger word: cable code or the six latched external lines
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tdata_reg <= TDATA_RST;
      end else if (cap_ts) begin
         tdata_reg <= code_s;
      end else if (cap_ext) begin
         tdata_reg <= ext_s;
      end else if (soft_clr) begin
         tdata_reg <= TDATA_RST;
      end
   end

   // valid flag: a capture in the clearing cycle is kept
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         valid_reg <= 1'b0;
      end else if (cap) begin
         valid_reg <= 1'b1;
      end else if (tdr_ack | soft_clr) begin
         valid_reg <= 1'b0;
      end
   end

   // station acknowledge held until the master strobes the next code,
   // so the master sees a steady level from every station
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         mack_reg <= 1'b0;
      end else if (tdr_ack & ~mode_ext) begin
         mack_reg <= 1'b1;
      end else if (strb_rise | soft_clr | mode_ext) begin
         mack_reg <= 1'b0;
      end
   end

   // own line replaces the chained one; other lines pass straight through
   always_comb begin
      ack_to_master = ack_from_next;
      ack_to_master[station_sel] = mack_reg;
   end

   // external sequencer: accept pulse, then busy until the host clears it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= EXT_IDLE;
         cnt_reg   <= '0;
      end else if (soft_clr) begin
         state_reg <= EXT_IDLE;
         cnt_reg   <= '0;
      end else begin
         unique case (state_reg)
            EXT_IDLE: begin
               if (cap_ext) begin
                  state_reg <= EXT_ACCEPT;
                  cnt_reg   <= ACCEPT_LAST;
               end
            end
            EXT_ACCEPT: begin
               if (tdr_ack) begin
                  state_reg <= EXT_IDLE;
               end else if (cnt_reg == '0) begin
                  state_reg <= EXT_BUSY;
               end else begin
                  cnt_reg <= cnt_reg - 6'h01;
               end
            end
            EXT_BUSY: begin
               if (tdr_ack) begin
                  state_reg <= EXT_IDLE;
               end
            end
            default: begin
               state_reg <= EXT_IDLE;
            end
         endcase
      end
   end

   assign prompt_accept = (state_reg == EXT_ACCEPT);
   assign busy          = (state_reg != EXT_IDLE);
   assign gp_out        = out_reg;

   // interrupt pending: a new request in the acknowledge cycle survives
   logic              irq_set;
   logic              iack_take;
   assign irq_set   = (cap & ctrl_reg[CSR_EN_INT]) | test_int;
   assign iack_take = iack_stb & ~iack_reg & pend_reg
                      & (iack_level == irq_level_sw);

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pend_reg <= 1'b0;
      end else if (irq_set & ~soft_clr) begin
         pend_reg <= 1'b1;
      end else if (iack_take | soft_clr) begin
         pend_reg <= 1'b0;
      end
   end

   // level zero switches the interrupter off
   assign irq_req = pend_reg & (irq_level_sw != 3'h0);

   // vector answer, one cycle pulse
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         iack_reg <= 1'b0;
         ivec_reg <= 8'h00;
      end else begin
         iack_reg <= iack_take;
         if (iack_take) begin
            ivec_reg <= vec_reg;
         end
      end
   end

   assign iack_ack    = iack_reg;
   assign iack_vector = ivec_reg;

   // read mux; input port samples the pins at the read itself
   logic [15:0]       rdat_next;
   always_comb begin
      rdat_next = 16'h0000;
      unique case (off)
         OFF_CSR: begin
            rdat_next[3:0]         = ctrl_reg;
            rdat_next[10:8]        = irq_level_sw;
            rdat_next[CSR_PEND]    = pend_reg;
            rdat_next[CSR_VALID]   = valid_reg;
         end
         OFF_VEC: begin
            rdat_next = HI_ONES | {8'h00, vec_reg};
         end
         OFF_TDR: begin
            rdat_next            = TDR_ONES | {10'h000, tdata_reg};
            rdat_next[TDR_MODE]  = mode_ext;
         end
         OFF_OUT: begin
            rdat_next = HI_ONES | {8'h00, out_reg};
         end
         OFF_INP: begin
            rdat_next = mode_ext ? ALL_ONES : {10'h000, ext_s};
         end
         default: begin
            rdat_next = 16'h0000;
         end
      endcase
   end

   // one wait state: ack or err rises the edge after the request,
   // drops the edge after; writes land on the edge ack rises
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_reg  <= 1'b0;
         err_reg  <= 1'b0;
         rdat_reg <= 16'h0000;
      end else begin
         ack_reg <= access & hit;
         err_reg <= access & ~hit;
         if (rd) begin
            rdat_reg <= rdat_next;
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_err_o = err_reg;
   assign wb_dat_o = rdat_reg;
endmodule

// ### test/trig_master_model.sv
`timescale 1ns/1ps
module trig_master_model (
   input  wire logic       core_clk,      // clock
   input  wire logic       req,           // issue one code per level
   input  wire logic [5:0] code,          // code to issue
   input  wire logic [7:0] ack_to_master, // chained acks
   output logic            cable_strobe,  // strobe pin
   output logic      [5:0] cable_code,    // code pins
   output logic      [7:0] ack_from_next  // other stations
);
   logic sent; // a code has gone out; never cleared
   // one frame per request; the next waits until every station has acked
   initial begin
      sent = 1'b0;
      cable_strobe = 1'b0;
      cable_code = 6'h3f;
      ack_from_next = 8'hff;
      forever begin
         @(posedge core_clk iff req);
         while (sent && ack_to_master !== 8'hff) begin
            @(posedge core_clk);
         end
         cable_code <= code;
         ack_from_next <= 8'h00;
         repeat (6) @(posedge core_clk);
         cable_strobe <= 1'b1;
         repeat (8) @(posedge core_clk);
         cable_strobe <= 1'b0;
         cable_code <= ~code; // released lines must not keep the code
         sent = 1'b1;
         repeat (20) @(posedge core_clk);
         ack_from_next <= 8'hff; // other stations finish quickly
         @(posedge core_clk iff !req);
      end
   end
endmodule

// ### test/trig_props.sv
`timescale 1ns/1ps
module trig_props
   import trig_pkg::*;
(
   input wire logic        core_clk,      // clock
   input wire logic        rst,           // async reset
   input wire logic        wb_cyc_i,      // cycle
   input wire logic        wb_stb_i,      // strobe
   input wire logic        wb_we_i,       // write
   input wire logic [15:0] wb_adr_i,      // address
   input wire logic [5:0]  am_i,          // modifier
   input wire logic        wb_ack_o,      // ack
   input wire logic        wb_err_o,      // refusal
   input wire logic [11:0] base_sw,       // base switches
   input wire logic [2:0]  irq_level_sw,  // level switches
   input wire logic        irq_req,       // request
   input wire logic        iack_stb,      // ack cycle
   input wire logic [2:0]  iack_level,    // acked level
   input wire logic        iack_ack,      // vector pulse
   input wire logic        prompt_accept, // accept
   input wire logic        busy,          // busy
   input wire logic [7:0]  gp_out         // output port
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   logic       req;  // bus request not yet answered
   logic       am_ok; // modifier is one of the two short ones
   logic [5:0] pcnt;  // cycles of the current accept pulse
   assign req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
   assign am_ok = am_i == AM_SHORT_SUP || am_i == AM_SHORT_USR;
   // counts accept width; an ack write may cut it short, so only full pulses are judged
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pcnt <= 6'h00;
      end else if (prompt_accept) begin
         pcnt <= pcnt + 6'h01;
      end else begin
         pcnt <= 6'h00;
      end
   end
   ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack wider than one cycle");
   answer_next_a: assert property (req |=> wb_ack_o ^ wb_err_o)
      else $error("request not answered once");
   am_refuse_a: assert property (req && !am_ok |=> wb_err_o && !wb_ack_o)
      else $error("bad modifier accepted");
   hit_accept_a: assert property (req && am_ok && wb_adr_i[15:4] == base_sw |=> wb_ack_o)
      else $error("valid access not acked");
   base_refuse_a: assert property (req && wb_adr_i[15:4] != base_sw |=> wb_err_o)
      else $error("foreign base accepted");
   prompt_busy_a: assert property (prompt_accept |-> busy)
      else $error("accept without busy");
   prompt_width_a: assert property ($fell(prompt_accept) && !(wb_cyc_i && wb_we_i) |-> pcnt == ACCEPT_LAST + 6'h01)
      else $error("accept width wrong");
   busy_hold_a: assert property (busy && !(wb_cyc_i && wb_we_i) |=> busy)
      else $error("busy dropped without host");
   port_hold_a: assert property (!(wb_cyc_i && wb_we_i) |=> $stable(gp_out))
      else $error("output port changed alone");
   level_zero_a: assert property (irq_level_sw == 3'h0 |-> !irq_req)
      else $error("request on level zero");
   iack_answer_a: assert property (iack_stb && irq_req && iack_level == irq_level_sw && !iack_ack
                                   |=> iack_ack && !irq_req)
      else $error("acknowledge not answered");
   cover property ($rose(busy));
   cover property (iack_ack);
   cover property (req ##1 wb_err_o);
endmodule

bind trigger_readout_interface trig_props i_props (
   .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .am_i(am_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .base_sw(base_sw),
   .irq_level_sw(irq_level_sw), .irq_req(irq_req), .iack_stb(iack_stb), .iack_level(iack_level),
   .iack_ack(iack_ack), .prompt_accept(prompt_accept), .busy(busy), .gp_out(gp_out));

// ### test/trigger_readout_interface_test.sv
`timescale 1ns/1ps
module trigger_readout_interface_test;
   import trig_pkg::*;
   localparam logic [15:0] BASE = 16'h0a50;
   typedef struct packed {
      logic        we;
      logic [3:0]  off;
      logic [15:0] d;
   } row_s;
   logic        core_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, irq_req, iack_stb, iack_ack;
   logic        cable_strobe, prompt_accept, busy, req, e;
   logic [15:0] wb_adr_i, wb_dat_i, wb_dat_o, q;
   logic [5:0]  am_i, cable_code, code;
   logic [2:0]  iack_level, flags, lvl;
   logic [7:0]  iack_vector, ack_from_next, ack_to_master, gp_out;
   logic [3:0]  ext_trig;
   logic [1:0]  ext_data;
   int          error_cnt, compares, cycles, n;
   // reads follow writes with the other modifier; first row is the reset value
   row_s rows [9] = '{'{1'b0, OFF_CSR, 16'h0300}, '{1'b1, OFF_VEC, 16'h005a}, '{1'b0, OFF_VEC, 16'hff5a},
                      '{1'b1, OFF_OUT, 16'h00c3}, '{1'b0, OFF_OUT, 16'hffc3}, '{1'b0, 4'ha, 16'h0000},
                      '{1'b1, OFF_CSR, 16'h0006}, '{1'b0, OFF_CSR, 16'h0306}, '{1'b0, OFF_INP, 16'h0025}};
   assign flags = {iack_ack, busy, irq_req};
   trigger_readout_interface i_dut (
      .core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
      .wb_adr_i(wb_adr_i), .wb_sel_i(2'b11), .wb_dat_i(wb_dat_i), .am_i(am_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .base_sw(BASE[15:4]), .irq_level_sw(lvl),
      .station_sel(3'h2), .irq_req(irq_req), .iack_stb(iack_stb), .iack_level(iack_level),
      .iack_ack(iack_ack), .iack_vector(iack_vector), .cable_strobe(cable_strobe),
      .cable_code(cable_code), .ack_from_next(ack_from_next), .ack_to_master(ack_to_master),
      .ext_trig(ext_trig), .ext_data(ext_data), .prompt_accept(prompt_accept), .busy(busy),
      .gp_out(gp_out));
   trig_master_model i_master (
      .core_clk(core_clk), .req(req), .code(code), .ack_to_master(ack_to_master),
      .cable_strobe(cable_strobe), .cable_code(cable_code), .ack_from_next(ack_from_next));
   task automatic complete_run();
      if (error_cnt == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input string s, input logic [15:0] x, input logic [15:0] g);
      compares++;
      if (g !== x) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", s, x, g);
      end
   endtask
   // one classic cycle, held until ack or err is sampled
   task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [5:0] m);
      int k;
      k = 0;
      @(posedge core_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= a;
      wb_dat_i <= d;
      am_i     <= m;
      do begin
         @(posedge core_clk);
         k++;
      end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && k < 50);
      chk("bus answer", 16'h0001, {15'h0000, wb_ack_o | wb_err_o});
      q = wb_dat_o;
      e = wb_err_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task automatic wr(input logic [3:0] o, input logic [15:0] d);
      bus(1'b1, BASE | 16'(o), d, AM_SHORT_SUP);
   endtask
   task automatic rd(input logic [3:0] o);
      bus(1'b0, BASE | 16'(o), 16'h0000, AM_SHORT_USR);
   endtask
   // bounded wait for irq_req (0), busy (1) or iack_ack (2)
   task automatic wait_hi(input int b);
      int k;
      k = 0;
      while (flags[b] !== 1'b1 && k < 300) begin
         @(posedge core_clk);
         k++;
      end
      chk("wait flag", 16'h0001, {15'h0000, flags[b]});
   endtask
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // hang guard, far above the few hundred cycles the run needs
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         error_cnt++;
         complete_run();
      end
   end
   initial begin
      {rst, wb_cyc_i, wb_stb_i, wb_we_i, iack_stb, req} = 6'h20;
      {wb_adr_i, wb_dat_i, am_i, iack_level, code} = 47'h0;
      lvl = 3'h3;
      ext_trig = 4'h5;
      ext_data = 2'b10;
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      chk("idle outs", 16'h0000, {5'h00, irq_req, prompt_accept, busy, gp_out});
      foreach (rows[i]) begin
         bus(rows[i].we, BASE | 16'(rows[i].off), rows[i].d, i[0] ? AM_SHORT_USR : AM_SHORT_SUP);
         chk("row err", 16'h0000, {15'h0000, e});
         if (!rows[i].we) chk("row read", rows[i].d, q);
      end
      chk("gp_out", 16'h00c3, {8'h00, gp_out});
      bus(1'b1, BASE | 16'(OFF_OUT), 16'h00ff, 6'h3d);
      chk("am err", 16'h0001, {15'h0000, e});
      bus(1'b1, 16'h0b56, 16'h00ff, AM_SHORT_SUP);
      chk("base err", 16'h0001, {15'h0000, e});
      chk("gp_out kept", 16'h00c3, {8'h00, gp_out});
      // cable mode with interrupts
      code <= 6'h2b;
      req <= 1'b1;
      wait_hi(0);
      rd(OFF_CSR);
      chk("csr valid", 16'hc306, q);
      iack_level <= 3'h3;
      iack_stb <= 1'b1;
      wait_hi(2);
      iack_stb <= 1'b0;
      chk("vector", 16'h005a, {8'h00, iack_vector});
      chk("irq drop", 16'h0000, {15'h0000, irq_req});
      rd(OFF_TDR);
      chk("cable data", 16'h7e2b, q);
      req <= 1'b0;
      // the master only rearms once it has seen the request low after its frame
      repeat (40) @(posedge core_clk);
      // second code asked early: must wait for our ack
      code <= 6'h14;
      req <= 1'b1;
      repeat (60) @(posedge core_clk);
      rd(OFF_TDR);
      chk("code held off", 16'h7e2b, q);
      wr(OFF_TDR, 16'h8000);
      chk("own ack", 16'h0001, {15'h0000, ack_to_master[2]});
      wait_hi(0);
      rd(OFF_TDR);
      chk("second code", 16'h7e14, q);
      req <= 1'b0;
      // level zero hides the pending request; then acknowledge it so ext mode starts clean
      lvl <= 3'h0;
      @(posedge core_clk);
      chk("level off", 16'h0000, {15'h0000, irq_req});
      lvl <= 3'h3;
      iack_stb <= 1'b1;
      wait_hi(2);
      iack_stb <= 1'b0;
      // external mode, triggers disabled first
      ext_trig <= 4'h0;
      ext_data <= 2'b01;
      wr(OFF_CSR, 16'h0001);
      ext_trig <= 4'h4;
      repeat (10) @(posedge core_clk);
      chk("disabled", 16'h0000, {15'h0000, busy});
      ext_trig <= 4'h0;
      wr(OFF_CSR, 16'h0003);
      repeat (6) @(posedge core_clk);
      ext_trig <= 4'h4;
      wait_hi(1);
      n = 0;
      while (prompt_accept === 1'b1 && n < 100) begin
         @(posedge core_clk);
         n++;
      end
      chk("prompt len", 16'(ACCEPT_CYCLES), 16'(n));
      ext_trig <= 4'h0;
      repeat (6) @(posedge core_clk);
      ext_trig <= 4'h1;
      repeat (8) @(posedge core_clk);
      rd(OFF_TDR);
      chk("ext data", 16'h7e94, q);
      rd(OFF_CSR);
      chk("ext poll", 16'h8303, q);
      chk("no irq", 16'h0000, {15'h0000, irq_req});
      rd(OFF_INP);
      chk("inp ext", 16'hffff, q);
      wr(OFF_TDR, 16'h8000);
      repeat (10) @(posedge core_clk);
      chk("busy clear", 16'h0000, {15'h0000, busy});
      // reset in mid-run
      rst <= 1'b1;
      @(posedge core_clk);
      rst <= 1'b0;
      rd(OFF_CSR);
      chk("csr reset", 16'h0300, q);
      chk("port reset", 16'h0000, {8'h00, gp_out});
      complete_run();
   end
endmodule
